// >>> common/diag_signal_pkg.sv
/*
 * Constants shared by the diagnostic interrupt and beep code signaller.
 * Assumes a 125 MHz controller clock; all times are converted to cycles here.
 */
package diag_signal_pkg;

    // Controller clock rate
    localparam int unsigned CLK_HZ           = 125_000_000;

    // Least diagnostic interrupt pulse width, in ms, and its cycle count (kHz rate rounded down, times ms)
    localparam int unsigned PULSE_MIN_MS     = 30;
    localparam int unsigned PULSE_MIN_CYC    = (CLK_HZ / 1000) * PULSE_MIN_MS;

    // Beep timing in ms: tone, gap inside a digit, gap between digits
    localparam int unsigned BEEP_ON_MS       = 200;
    localparam int unsigned BEEP_GAP_MS      = 200;
    localparam int unsigned DIGIT_GAP_MS     = 800;
    localparam int unsigned BEEP_ON_CYC      = (CLK_HZ / 1000) * BEEP_ON_MS;
    localparam int unsigned BEEP_GAP_CYC     = (CLK_HZ / 1000) * BEEP_GAP_MS;
    localparam int unsigned DIGIT_GAP_CYC    = (CLK_HZ / 1000) * DIGIT_GAP_MS;

    // Beep code layout: four digits of four bits, first digit in the top nibble
    localparam int unsigned DIGITS           = 4;
    localparam int unsigned DIGIT_W          = 4;
    localparam int unsigned CODE_W           = DIGITS * DIGIT_W;

    // Failure causes, one bit each, lowest index wins when several arrive at once
    localparam int unsigned CAUSE_N          = 6;
    localparam int unsigned CAUSE_CPU_MISS   = 0;
    localparam int unsigned CAUSE_SKU_MISM   = 1;
    localparam int unsigned CAUSE_PWR_FAULT  = 2;
    localparam int unsigned CAUSE_PWR_CTRL   = 3;
    localparam int unsigned CAUSE_VREG_WDT   = 4;
    localparam int unsigned CAUSE_PSU_COMPAT = 5;

    // Beep codes per cause
    localparam logic [15:0] CODE_CPU_MISS    = 16'h1521;
    localparam logic [15:0] CODE_SKU_MISM    = 16'h1524;
    localparam logic [15:0] CODE_PWR_FAULT   = 16'h1542;
    localparam logic [15:0] CODE_PWR_CTRL    = 16'h1544;
    localparam logic [15:0] CODE_VREG_WDT    = 16'h1512;
    localparam logic [15:0] CODE_PSU_COMPAT  = 16'h1514;

endpackage

// >>> core/beep_sequencer.sv
/*
 * Plays one four-digit beep code on a beeper output.
 * Assumes a single-cycle start strobe from logic on the same clock, taken only when idle.
 */
module beep_sequencer
    import diag_signal_pkg::*;
#(
    parameter int unsigned ON_CYC    = BEEP_ON_CYC,
    parameter int unsigned GAP_CYC   = BEEP_GAP_CYC,
    parameter int unsigned DGAP_CYC  = DIGIT_GAP_CYC
)
(
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_n_i,
    // Request
    input  wire logic                 start_i,
    input  wire logic [CODE_W-1:0]    code_i,
    // Result
    output logic                      beep_o,
    output logic                      busy_o
);

    // Elaboration check: the timer is 28 bits and the digit gap must outlast the beep gap
    if (ON_CYC < 1 || GAP_CYC < 1 || DGAP_CYC <= GAP_CYC || DGAP_CYC >= 2**28)
    begin : g_bad_timing
        $error("beep_sequencer: bad timing parameters");
    end

    typedef enum logic [1:0] {S_IDLE, S_ON, S_GAP} seq_state_t;

    typedef struct packed {
        seq_state_t          state;   // Sequencer phase
        logic [CODE_W-1:0]   code;    // Remaining digits, current in top nibble
        logic [2:0]          digit;   // Digits still to play, counting the current
        logic [DIGIT_W-1:0]  left;    // Beeps left in the current digit
        logic [27:0]         timer;   // Phase timer
        logic                beep;    // Tone output
        logic                busy;    // Code playing; a flop, so the port has no decode
    } seq_t;

    seq_t cur;
    seq_t next_cur;

    // Sequencer step: each digit gives as many beeps as its value, in order
    always_comb
    begin
        next_cur = cur;
        case (cur.state)
            S_IDLE:
            begin
                if (start_i)
                begin
                    next_cur.code  = code_i;
                    next_cur.digit = 3'(DIGITS);
                    next_cur.left  = code_i[CODE_W-1 -: DIGIT_W];
                    next_cur.timer = 28'(ON_CYC - 1);
                    // A zero digit plays no beep; treat it as a silent gap
                    next_cur.state = (code_i[CODE_W-1 -: DIGIT_W] != '0) ? S_ON : S_GAP;
                    next_cur.beep  = (code_i[CODE_W-1 -: DIGIT_W] != '0);
                end
            end
            S_ON:
            begin
                if (cur.timer != '0)
                    next_cur.timer = cur.timer - 28'h0000001;
                else
                begin
                    next_cur.beep  = 1'b0;
                    next_cur.left  = cur.left - 4'h1;
                    // Longer gap after the digit's last beep keeps groups apart
                    next_cur.timer = (cur.left == 4'h1) ? 28'(DGAP_CYC - 1)
                                                        : 28'(GAP_CYC - 1);
                    next_cur.state = S_GAP;
                end
            end
            S_GAP:
            begin
                if (cur.timer != '0)
                    next_cur.timer = cur.timer - 28'h0000001;
                else if (cur.left != '0)
                begin
                    next_cur.beep  = 1'b1;
                    next_cur.timer = 28'(ON_CYC - 1);
                    next_cur.state = S_ON;
                end
                else if (cur.digit > 3'h1)
                begin
                    // Advance to the next digit in order
                    next_cur.code  = {cur.code[CODE_W-DIGIT_W-1:0], 4'h0};
                    next_cur.digit = cur.digit - 3'h1;
                    next_cur.left  = cur.code[CODE_W-DIGIT_W-1 -: DIGIT_W];
                    next_cur.timer = 28'(ON_CYC - 1);
                    next_cur.beep  = (cur.code[CODE_W-DIGIT_W-1 -: DIGIT_W] != '0);
                    next_cur.state = next_cur.beep ? S_ON : S_GAP;
                end
                else
                    next_cur.state = S_IDLE;
            end
            default:
                next_cur.state = S_IDLE;
        endcase
        // Busy follows the phase, registered with it
        next_cur.busy = (next_cur.state != S_IDLE);
    end

    // State register
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cur <= '{state: S_IDLE, default: '0};
        else
            cur <= next_cur;
    end

    assign beep_o = cur.beep;
    assign busy_o = cur.busy;

endmodule // beep_sequencer

// >>> core/diag_interrupt_beep_signaller.sv
/*
 * Diagnostic interrupt pulse generator and failure beep code signaller.
 * Assumes pin-level inputs from the platform (synchronised here) and single-cycle
 * request strobes from controller logic on the same clock.
 * The button, the clear pins and the detection levels may change at any time;
 * the chassis request, the pre-timeout and its selector are already synchronous.
 * Logging itself happens elsewhere: this block only raises a one-cycle strobe.
 */
// Summary of operation
// - Interrupt pulse lasts at least 30 ms
// - One pulse, then locked until reset/power-down
// - Chassis-control request pulses the interrupt
// - Chassis-control pulse logs no event
// - Panel button pulses and logs sensor event
// - Watchdog pre-timeout pulses, logs no event
// - Beep code once per detection, never continuous
// - Each digit beeps its value, in order
// - Missing processor and identifier mismatch codes
// - Power-good dropout gives power-fault code
// - Power-good timeout gives power-control code
// - Regulator watchdog gives its own code
// - Incompatible supply at power failure coded
module diag_interrupt_beep_signaller
    import diag_signal_pkg::*;
#(
    parameter int unsigned PULSE_CYC = PULSE_MIN_CYC,
    parameter int unsigned ON_CYC    = BEEP_ON_CYC,
    parameter int unsigned GAP_CYC   = BEEP_GAP_CYC,
    parameter int unsigned DGAP_CYC  = DIGIT_GAP_CYC
)
(
    // Clock and reset
    input  wire logic    core_clk_i,
    input  wire logic    reset_n_i,
    // System state (clears lockout)
    input  wire logic    sys_reset_i,
    input  wire logic    power_down_i,
    // Interrupt triggers
    input  wire logic    chassis_pulse_req_i,
    input  wire logic    panel_button_n_i,
    input  wire logic    wdt_pretimeout_i,
    input  wire logic    pretimeout_nmi_sel_i,
    // Failure detections
    input  wire logic    cpu_missing_i,
    input  wire logic    model_sku_identifier_mismatch_i,
    input  wire logic    power_good_dropout_i,
    input  wire logic    power_good_timeout_i,
    input  wire logic    voltage_regulator_wdt_i,
    input  wire logic    power_supply_unit_incompat_i,
    // Outputs
    output logic         diag_nmi_o,
    output logic         panel_event_log_o,
    output logic         beep_o,
    output logic         beep_busy_o
);

    // Elaboration check: the pulse counter is 24 bits wide and must count at least once
    // Beep timing is checked inside the sequencer, next to the timer it loads
    if (PULSE_CYC < 1 || PULSE_CYC >= 2**24)
    begin : g_bad_pulse
        $error("diag_interrupt_beep_signaller: bad pulse width");
    end

    // Per-code lookup, indexed by cause
    // The first cause sits in the lowest slice, matching the cause bit order
    localparam logic [CAUSE_N*CODE_W-1:0] CODE_TABLE =
        {CODE_PSU_COMPAT, CODE_VREG_WDT, CODE_PWR_CTRL,
         CODE_PWR_FAULT, CODE_SKU_MISM, CODE_CPU_MISS};

    // All state of this block, registered as one word by one always_ff
    typedef struct packed {
        logic [1:0]          btn_sync;    // Button synchroniser (active level)
        logic                btn_prev;    // Last synchronised button level
        logic [1:0]          rst_sync;    // System reset synchroniser
        logic [1:0]          pdn_sync;    // Power-down synchroniser
        logic [CAUSE_N-1:0]  cause_s1;    // Cause synchroniser, first stage
        logic [CAUSE_N-1:0]  cause_s2;    // Cause synchroniser, second stage
        logic [CAUSE_N-1:0]  cause_prev;  // Previous cause levels for edges
        logic [CAUSE_N-1:0]  pending;     // Detected, not yet played
        logic                nmi;         // Interrupt output
        logic                locked;      // Lockout after one pulse
        logic [23:0]         pulse_cnt;   // Pulse width counter
        logic                log_evt;     // Sensor event strobe
        logic                start;       // Beep start strobe
        logic [CODE_W-1:0]   code;        // Code handed to the sequencer
    } sig_t;

    // Present state and the value it takes at the next edge
    sig_t cur;
    sig_t next_cur;

    // Helpers decoded from the state and the inputs, all but the raw cause_in levels on the controller clock
    logic                beep_raw;    // Tone from the sequencer flop
    logic                seq_busy;    // Sequencer playing, from its flop
    logic [CAUSE_N-1:0]  cause_in;    // Raw detection levels, cause order
    logic [CAUSE_N-1:0]  cause_rise;  // New detections this cycle
    logic [CAUSE_N-1:0]  pick;        // Lowest pending cause, one-hot
    logic                btn_press;   // Button press edge
    logic                clear_lock;  // Synchronised reset or power-down

    assign cause_in[CAUSE_CPU_MISS]   = cpu_missing_i;
    assign cause_in[CAUSE_SKU_MISM]   = model_sku_identifier_mismatch_i;
    assign cause_in[CAUSE_PWR_FAULT]  = power_good_dropout_i;
    assign cause_in[CAUSE_PWR_CTRL]   = power_good_timeout_i;
    assign cause_in[CAUSE_VREG_WDT]   = voltage_regulator_wdt_i;
    assign cause_in[CAUSE_PSU_COMPAT] = power_supply_unit_incompat_i;

    // Limitation: a level that drops and returns while still pending plays only once
    // Edges only: a level that stays asserted plays once, not continuously
    assign cause_rise = cur.cause_s2 & ~cur.cause_prev;
    assign btn_press  = cur.btn_sync[1] & ~cur.btn_prev;
    // Either clear pin, once synchronised, releases the lockout
    assign clear_lock = cur.rst_sync[1] | cur.pdn_sync[1];

    // One-hot pick of the lowest pending cause
    // A chain of masks; with six causes the path stays short
    genvar g;
    generate
        for (g = 0; g < CAUSE_N; g++)
        begin : g_pick
            // The lowest cause needs no mask
            if (g == 0)
                assign pick[g] = cur.pending[g];
            else
                assign pick[g] = cur.pending[g] & ~|cur.pending[g-1:0];
        end
    endgenerate

    // Next-state logic
    always_comb
    begin
        next_cur            = cur;
        // Synchronisers: two flops stand before any logic reads a pin
        next_cur.btn_sync   = {cur.btn_sync[0], ~panel_button_n_i};
        next_cur.btn_prev   = cur.btn_sync[1];
        next_cur.rst_sync   = {cur.rst_sync[0], sys_reset_i};
        next_cur.pdn_sync   = {cur.pdn_sync[0], power_down_i};
        // Detections: two flops, then one more for the edge
        next_cur.cause_s1   = cause_in;
        next_cur.cause_s2   = cur.cause_s1;
        next_cur.cause_prev = cur.cause_s2;
        // Strobes default low, so each lasts exactly one cycle
        next_cur.log_evt    = 1'b0;
        next_cur.start      = 1'b0;

        // Interrupt pulse: runs its full width even if reset arrives meanwhile
        // Triggers that arrive while pulsing or locked are dropped; a button press still logs its event
        if (cur.nmi)
        begin
            // Count down to zero, then drop the line
            if (cur.pulse_cnt != '0)
                next_cur.pulse_cnt = cur.pulse_cnt - 24'h000001;
            else
                next_cur.nmi = 1'b0;
        end
        // Clear waits until no pulse runs, so a pulse is never cut short
        else if (clear_lock)
            next_cur.locked = 1'b0;
        // Any trigger, when unlocked, starts the one pulse of this lock period
        else if (!cur.locked
                 && (chassis_pulse_req_i
                     || btn_press
                     || (wdt_pretimeout_i && pretimeout_nmi_sel_i)))
        begin
            // Start: raise, lock, load width minus one (the zero cycle counts too)
            next_cur.nmi       = 1'b1;
            next_cur.locked    = 1'b1;
            next_cur.pulse_cnt = 24'(PULSE_CYC - 1);
        end

        // Only the button logs a sensor event, whether or not it pulsed
        // The strobe follows every press, even one refused by the lockout
        next_cur.log_evt = btn_press;

        // Beep queue: new detections set pending, set wins over taking one
        // The start strobe blocks one more cycle, until the sequencer's busy is up
        if (!seq_busy && !cur.start && (cur.pending != '0))
        begin
            next_cur.start = 1'b1;
            next_cur.code  = '0;
            // Only one bit of pick is set, so the loop yields one code
            for (int i = 0; i < CAUSE_N; i++)
                if (pick[i])
                    next_cur.code = CODE_TABLE[i*CODE_W +: CODE_W];
            next_cur.pending = (cur.pending & ~pick) | cause_rise;
        end
        else
            next_cur.pending = cur.pending | cause_rise;
    end

    // State register
    // Asynchronous reset loads constants only; every output starts low
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // Beep code player
    // Timing counts pass straight through; the sequencer checks them itself
    beep_sequencer #(
        .ON_CYC   (ON_CYC),
        .GAP_CYC  (GAP_CYC),
        .DGAP_CYC (DGAP_CYC)
    ) u_beep (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .start_i    (cur.start),
        .code_i     (cur.code),
        .beep_o     (beep_raw),
        .busy_o     (seq_busy)
    );

    // Every output comes straight from a flop, here or in the sequencer
    assign diag_nmi_o        = cur.nmi;
    assign panel_event_log_o = cur.log_evt;
    assign beep_o            = beep_raw;
    assign beep_busy_o       = seq_busy;

endmodule // diag_interrupt_beep_signaller

// >>> bench/diag_signaller_sva.sv
/*
 * Port checks for the diagnostic interrupt and beep code signaller.
 * Assumes one controller clock; shortened counts come in through the bind.
 */
module diag_signaller_sva
#(
    parameter int unsigned PULSE_CYC = 20,
    parameter int unsigned ON_CYC    = 3,
    parameter int unsigned GAP_CYC   = 2,
    parameter int unsigned DGAP_CYC  = 6
)
(
    // Clock, reset and watched inputs
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic sys_reset_i,
    input  wire logic power_down_i,
    input  wire logic chassis_pulse_req_i,
    input  wire logic panel_button_n_i,
    input  wire logic wdt_pretimeout_i,
    input  wire logic pretimeout_nmi_sel_i,
    input  wire logic cpu_missing_i,
    // Watched outputs
    input  wire logic diag_nmi_o,
    input  wire logic panel_event_log_o,
    input  wire logic beep_o,
    input  wire logic beep_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] nmi_cnt;  // High cycles of the running pulse
    logic [31:0] on_cnt;   // High cycles of the running beep
    logic [31:0] off_cnt;  // Low cycles while a code plays
    logic        locked;   // One pulse already given
    logic [2:0]  quiet;    // Cycles since the clear pins fell, capped

    // Loose lock model: clears as soon as a pin shows, so it never blames the design early
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            nmi_cnt <= '0;
            on_cnt  <= '0;
            off_cnt <= '0;
            locked  <= 1'b0;
            quiet   <= 3'h0;
        end
        else
        begin
            nmi_cnt <= diag_nmi_o ? nmi_cnt + 1 : '0;
            on_cnt  <= beep_o ? on_cnt + 1 : '0;
            off_cnt <= (beep_busy_o && !beep_o) ? off_cnt + 1 : '0;
            quiet   <= (sys_reset_i || power_down_i) ? 3'h0 : ((quiet == 3'h4) ? quiet : quiet + 1);
            if (diag_nmi_o)
                locked <= 1'b1;
            else if (sys_reset_i || power_down_i)
                locked <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    nmi_width_a: assert property ($fell(diag_nmi_o) |-> nmi_cnt == PULSE_CYC)
        else $error("interrupt pulse width wrong");
    nmi_lock_a: assert property ($rose(diag_nmi_o) |-> !locked)
        else $error("interrupt pulse while locked");
    chassis_take_a: assert property (chassis_pulse_req_i && !locked && !diag_nmi_o
        && quiet == 3'h4 |=> diag_nmi_o)
        else $error("chassis request not answered");
    wdt_take_a: assert property (wdt_pretimeout_i && pretimeout_nmi_sel_i && !locked
        && !diag_nmi_o && quiet == 3'h4 |=> diag_nmi_o)
        else $error("pre-timeout not answered");
    log_press_a: assert property ($fell(panel_button_n_i) |-> ##[2:4] panel_event_log_o)
        else $error("button press not logged");
    log_cause_a: assert property (panel_event_log_o |-> !$past(panel_button_n_i, 2))
        else $error("event logged without button");
    beep_on_a: assert property ($fell(beep_o) |-> on_cnt == ON_CYC)
        else $error("beep length wrong");
    beep_gap_a: assert property ($rose(beep_o) && off_cnt != 0
        |-> off_cnt == GAP_CYC || off_cnt == DGAP_CYC)
        else $error("beep gap wrong");
    beep_busy_a: assert property (beep_o |-> beep_busy_o)
        else $error("beep outside a code");
    beep_start_a: assert property ($rose(cpu_missing_i) && !beep_busy_o
        |-> ##[2:8] beep_busy_o)
        else $error("detection did not start a code");

    cover property ($rose(diag_nmi_o));
    cover property (panel_event_log_o && !diag_nmi_o);
    cover property ($fell(beep_busy_o));
endmodule // diag_signaller_sva

bind diag_interrupt_beep_signaller diag_signaller_sva #(.PULSE_CYC(PULSE_CYC), .ON_CYC(ON_CYC),
    .GAP_CYC(GAP_CYC), .DGAP_CYC(DGAP_CYC)) diag_signaller_sva_inst (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .sys_reset_i(sys_reset_i), .power_down_i(power_down_i),
    .chassis_pulse_req_i(chassis_pulse_req_i), .panel_button_n_i(panel_button_n_i),
    .wdt_pretimeout_i(wdt_pretimeout_i), .pretimeout_nmi_sel_i(pretimeout_nmi_sel_i),
    .cpu_missing_i(cpu_missing_i), .diag_nmi_o(diag_nmi_o),
    .panel_event_log_o(panel_event_log_o), .beep_o(beep_o), .beep_busy_o(beep_busy_o));

// >>> bench/host_beeper_model.sv
/*
 * Host interrupt input and platform beeper: counts pulses, measures them, decodes beeps.
 * Assumes the controller clock; a low run longer than the in-digit gap ends a digit.
 */
module host_beeper_model
#(
    parameter int unsigned GAP_CYC = 2
)
(
    // Clock, reset and observed lines
    input  wire logic  core_clk_i,
    input  wire logic  reset_n_i,
    input  wire logic  diag_nmi_i,
    input  wire logic  beep_i,
    // Observations
    output logic [31:0] nmi_rises_o,
    output logic [31:0] nmi_width_o,
    output logic [15:0] code_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        nmi_q;    // Last interrupt level
    logic        beep_q;   // Last beeper level
    logic [31:0] nmi_run;  // High cycles so far
    logic [31:0] low_run;  // Quiet cycles so far
    logic [3:0]  beeps;    // Beeps in the current digit

    // Digits shift in from the right, so after four the first sits on top
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            {nmi_q, beep_q, nmi_run, low_run, beeps} <= '0;
            {nmi_rises_o, nmi_width_o, code_o} <= '0;
        end
        else
        begin
            nmi_q   <= diag_nmi_i;
            beep_q  <= beep_i;
            nmi_run <= diag_nmi_i ? nmi_run + 1 : '0;
            low_run <= beep_i ? '0 : low_run + 1;
            if (diag_nmi_i && !nmi_q)
                nmi_rises_o <= nmi_rises_o + 1;
            if (!diag_nmi_i && nmi_q)
                nmi_width_o <= nmi_run;
            if (beep_i && !beep_q)
                beeps <= beeps + 1;
            else if (!beep_i && low_run == GAP_CYC && beeps != 0)
            begin
                code_o <= {code_o[11:0], beeps};
                beeps  <= '0;
            end
        end
    end
endmodule // host_beeper_model

// >>> bench/testbench.sv
/*
 * Self-checking bench for the signaller with shortened pulse and beep counts.
 * Assumes inputs change 1 ns after the rising edge.
 */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned PW = 20;  // Shortened pulse width

    logic core_clk = 0, reset_n = 0, sys_reset = 0, power_down = 0, chassis = 0;
    logic button_n = 1, wdt = 0, nmi_sel = 0, nmi, log_ev, beep, busy;
    logic [5:0]  cause = '0;  // Detection levels, one per failure
    logic [31:0] rises, width;
    logic [15:0] code;
    int n_mismatch = 0, comparisons = 0, n_log = 0, r0, l0;

    always #4 core_clk = ~core_clk;
    // Count log pulses where they are settled
    always @(posedge core_clk)
        if (log_ev === 1'b1)
            n_log++;

    diag_interrupt_beep_signaller #(.PULSE_CYC(PW), .ON_CYC(3), .GAP_CYC(2), .DGAP_CYC(6))
        diag_interrupt_beep_signaller_inst (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .sys_reset_i(sys_reset), .power_down_i(power_down), .chassis_pulse_req_i(chassis),
        .panel_button_n_i(button_n), .wdt_pretimeout_i(wdt), .pretimeout_nmi_sel_i(nmi_sel),
        .cpu_missing_i(cause[0]), .model_sku_identifier_mismatch_i(cause[1]),
        .power_good_dropout_i(cause[2]), .power_good_timeout_i(cause[3]),
        .voltage_regulator_wdt_i(cause[4]), .power_supply_unit_incompat_i(cause[5]),
        .diag_nmi_o(nmi), .panel_event_log_o(log_ev), .beep_o(beep), .beep_busy_o(busy));
    host_beeper_model #(.GAP_CYC(2)) host_beeper_model_inst (.core_clk_i(core_clk),
        .reset_n_i(reset_n), .diag_nmi_i(nmi), .beep_i(beep), .nmi_rises_o(rises),
        .nmi_width_o(width), .code_o(code));

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Hold a clear pin long enough for the synchroniser and any running pulse
    task automatic clear_lock(bit by_power);
        cyc(PW + 2);
        if (by_power) power_down = 1; else sys_reset = 1;
        cyc(5);
        {sys_reset, power_down} = 2'b00;
        cyc(5);
    endtask

    task automatic t_chassis();
        r0 = rises;
        l0 = n_log;
        chassis = 1;
        cyc(1);
        chassis = 0;
        cyc(1);
        check("nmi rise", nmi, 1);
        cyc(PW + 2);
        check("nmi width", width, PW);
        check("chassis log", n_log, l0);
        chassis = 1;
        cyc(1);
        chassis = 0;
        cyc(PW);
        check("locked pulses", rises, r0 + 1);
        clear_lock(0);
        chassis = 1;
        cyc(1);
        chassis = 0;
        cyc(2);
        check("after clear", rises, r0 + 2);
        clear_lock(1);
        $display("chassis test done");
    endtask

    task automatic t_button();
        r0 = rises;
        l0 = n_log;
        button_n = 0;
        cyc(10);
        button_n = 1;
        check("button log", n_log, l0 + 1);
        check("button nmi", rises, r0 + 1);
        cyc(5);
        button_n = 0;
        cyc(10);
        button_n = 1;
        check("locked log", n_log, l0 + 2);
        check("locked nmi", rises, r0 + 1);
        clear_lock(1);
        $display("button test done");
    endtask

    task automatic t_wdt();
        r0 = rises;
        l0 = n_log;
        wdt = 1;
        cyc(1);
        wdt = 0;
        cyc(5);
        check("unselected wdt", rises, r0);
        nmi_sel = 1;
        wdt = 1;
        cyc(1);
        wdt = 0;
        cyc(3);
        check("wdt nmi", rises, r0 + 1);
        check("wdt log", n_log, l0);
        clear_lock(0);
        $display("watchdog test done");
    endtask

    task automatic t_beep();
        logic [15:0] exp [6] = '{16'h1521, 16'h1524, 16'h1542, 16'h1544, 16'h1512, 16'h1514};
        for (int i = 0; i < 6; i++)
        begin
            repeat (2)
            begin
                cause[i] = 1;
                for (int k = 0; k < 50 && busy !== 1'b1; k++) cyc(1);
                for (int k = 0; k < 2000 && busy !== 1'b0; k++) cyc(1);
                check("beep code", code, exp[i]);
                cyc(40);
                check("no repeat", busy, 0);
                cause[i] = 0;
                cyc(5);
            end
        end
        $display("beep test done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 20k cycles
    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end

    initial
    begin
        cyc(5);
        reset_n = 1;
        cyc(1);
        t_chassis();
        t_button();
        t_wdt();
        t_beep();
        final_report();
    end
endmodule // testbench
